// file: logic/sar_pkg.sv
package sar_pkg;
  localparam int unsigned CODE_W = 16;
  localparam int unsigned CLK_MHZ = 50;
  // Conversion time, least and longest
  localparam int unsigned CONV_MIN_NS = 1000;
  localparam int unsigned CONV_MAX_NS = 1500;
  localparam int unsigned CONV_CYC = (CONV_MIN_NS * CLK_MHZ + 999) / 1000;
  // Host spacing limits kept for reference only; neither the logic nor the bench uses them
  localparam int unsigned CNV_LOW_MIN_NS = 20;
  localparam int unsigned CNV_QUIET_NS = 20;
  localparam int unsigned CYCLE_MIN_NS = 2000;
  // Gain compression: scaled = code * 4/5 (10% to 90% of span)
  localparam int unsigned GC_NUM = 4;
  localparam int unsigned GC_DEN = 5;
  localparam logic [15:0] CODE_RST = 16'h0000;
  typedef enum logic [1:0] {
    SAR_IDLE = 2'b00,
    SAR_CONV = 2'b01,
    SAR_DONE = 2'b11
  } sar_state_e;
endpackage

// file: logic/sar_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sar_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sar_sync_s;
  sar_sync_s st_r;
  sar_sync_s st_nxt;
  always_comb
  begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
    if (!nrst)
    begin
      st_nxt = '0;
    end
  end
  always_ff @(posedge clk)
  begin
    st_r <= st_nxt;
  end
  assign q = st_r.s2;
endmodule
`default_nettype wire

// file: logic/sar_shift.sv
`timescale 1ns/1ps
`default_nettype none
module sar_shift #(
  parameter int unsigned W = 16
) (
  // Link clock and reset
  input wire logic shift_clk,
  input wire logic nrst_link,
  // Load from core domain (toggle)
  input wire logic load_tgl,
  input wire logic [W-1:0] load_word,
  // Serial
  input wire logic chain_mode,
  input wire logic serial_in,
  output logic serial_out
);
  typedef struct packed {
    logic [W-1:0] sh;
    logic t1;
    logic t2;
    logic t3;
    logic c1;
    logic c2;
  } sar_shift_s;
  sar_shift_s st_r;
  sar_shift_s st_nxt;
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.t1 = load_tgl;
    st_nxt.t2 = st_r.t1;
    st_nxt.t3 = st_r.t2;
    // Mode crosses from the core domain through two stages
    st_nxt.c1 = chain_mode;
    st_nxt.c2 = st_r.c1;
    if (st_r.t2 != st_r.t3)
    begin
      st_nxt.sh = load_word;
    end
    else
    begin
      st_nxt.sh = {st_r.sh[W-2:0], st_r.c2 & serial_in};
    end
    if (!nrst_link)
    begin
      st_nxt = '0;
    end
  end
  always_ff @(posedge shift_clk)
  begin
    st_r <= st_nxt;
  end
  assign serial_out = st_r.sh[W-1];
endmodule
`default_nettype wire

// file: logic/sar_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Convert strobe rise starts new conversion
// - Busy high during conversion only
// - Chain low: shared pin enables output
// - Chain high: shared pin is serial input
// - Shift out MSB first on rising edges
// - Output carries own or upstream data
// - Result in two's complement
// - Gain compression maps span to 10-90%
// - Drive output while enable low
// - Prepare 16-bit code at conversion end
module sar_ctrl
  import sar_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = sar_pkg::CONV_CYC
) (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Link clock and its reset
  input wire logic shift_clk,
  input wire logic nrst_link,
  // Conversion control
  input wire logic convert_strobe,
  output logic busy,
  // Analog result from comparator array, offset binary
  input wire logic [sar_pkg::CODE_W-1:0] sample_code,
  // Straps
  input wire logic chain_select,
  input wire logic gain_compress_select,
  // Shared pin and serial output
  input wire logic shared_enable_or_serial_in,
  output logic serial_out,
  output logic serial_out_oe
);
  import sar_pkg::*;
  localparam int unsigned CNT_W = $clog2(CONV_CYCLES + 1);
  initial
  begin
    if (CONV_CYCLES < 1)
    begin
      $error("CONV_CYCLES must be at least one");
    end
  end
  typedef struct packed {
    sar_state_e state;
    logic [CNT_W-1:0] cnt;
    logic cnv_d;
    logic busy;
    logic gain_compression;
    logic [CODE_W-1:0] code;
    logic tgl;
    logic chain;
    logic oe;
  } sar_ctrl_s;
  sar_ctrl_s st_r;
  sar_ctrl_s st_nxt;
  logic [2:0] pins_s;
  logic cnv_s;
  logic chain_s;
  logic gc_s;
  logic sdo_int;
  logic en_s;
  sar_sync #(.W(3)) u_sync (
    .clk(core_clk),
    .nrst(nrst),
    .d({convert_strobe, chain_select, gain_compress_select}),
    .q(pins_s)
  );
  assign cnv_s = pins_s[2];
  assign chain_s = pins_s[1];
  assign gc_s = pins_s[0];
  // Enable carried active high so the reset value means not enabled
  sar_sync #(.W(1)) u_sync_en (
    .clk(core_clk),
    .nrst(nrst),
    .d(~shared_enable_or_serial_in),
    .q(en_s)
  );
  function automatic logic [CODE_W-1:0] to_twos(input logic [CODE_W-1:0] ob, input logic gc);
    logic [CODE_W+2:0] prod;
    logic [CODE_W-1:0] tc;
    prod = '0;
    tc = {~ob[CODE_W-1], ob[CODE_W-2:0]};
    if (gc)
    begin
      prod = {{3{tc[CODE_W-1]}}, tc} * (CODE_W+3)'(GC_NUM);
      tc = CODE_W'($signed(prod) / $signed((CODE_W+3)'(GC_DEN)));
    end
    return tc;
  endfunction
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.cnv_d = cnv_s;
    st_nxt.chain = chain_s;
    st_nxt.oe = chain_s | en_s;
    unique case (st_r.state)
      SAR_IDLE:
      begin
        st_nxt.gain_compression = ~gc_s;
        if (cnv_s && !st_r.cnv_d)
        begin
          st_nxt.state = SAR_CONV;
          st_nxt.busy = 1'b1;
          st_nxt.cnt = '0;
        end
      end
      SAR_CONV:
      begin
        st_nxt.cnt = st_r.cnt + CNT_W'(1);
        if (st_r.cnt == CNT_W'(CONV_CYCLES - 1))
        begin
          st_nxt.state = SAR_DONE;
          st_nxt.code = to_twos(sample_code, st_r.gain_compression);
          st_nxt.tgl = ~st_r.tgl;
        end
      end
      SAR_DONE:
      begin
        st_nxt.busy = 1'b0;
        st_nxt.state = SAR_IDLE;
      end
    endcase
    if (!nrst)
    begin
      st_nxt = '0;
      st_nxt.state = SAR_IDLE;
      st_nxt.code = CODE_RST;
    end
  end
  always_ff @(posedge core_clk)
  begin
    st_r <= st_nxt;
  end
  sar_shift #(.W(CODE_W)) u_shift (
    .shift_clk(shift_clk),
    .nrst_link(nrst_link),
    .load_tgl(st_r.tgl),
    .load_word(st_r.code),
    .chain_mode(st_r.chain),
    .serial_in(shared_enable_or_serial_in),
    .serial_out(sdo_int)
  );
  assign busy = st_r.busy;
  assign serial_out = sdo_int;
  assign serial_out_oe = st_r.oe;
endmodule
`default_nettype wire

// file: verification/sar_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sar_ctrl_properties #(
  parameter int unsigned CONV_CYCLES = 50
) (
  // Core side
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic convert_strobe,
  input wire logic busy,
  // Output gating
  input wire logic chain_select,
  input wire logic shared_enable_or_serial_in,
  input wire logic serial_out_oe
);
  int n_r;
  always_ff @(posedge core_clk)
  begin
    n_r <= (nrst && busy) ? n_r + 1 : 0;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_go;
    $rose(convert_strobe) && !busy;
  endsequence
  go_busy_a: assert property (s_go |-> ##[2:5] busy) else $error("late");
  go_wait_a: assert property (s_go |=> !busy) else $error("early");
  busy_len_a: assert property ($fell(busy) |-> n_r >= CONV_CYCLES && n_r <= CONV_CYCLES + 2)
    else $error("length");
  busy_idle_a: assert property ((!convert_strobe)[*6] |=> !$rose(busy)) else $error("spurious");
  busy_cause_a: assert property ($rose(busy) |-> $past(convert_strobe, 3) || $past(convert_strobe, 4))
    else $error("cause");
  oe_off_a: assert property ((!chain_select && shared_enable_or_serial_in)[*8] |-> !serial_out_oe)
    else $error("oe on");
  oe_on_a: assert property ((!chain_select && !shared_enable_or_serial_in)[*8] |-> serial_out_oe)
    else $error("oe off");
  oe_chain_a: assert property (chain_select[*8] |-> serial_out_oe) else $error("chain oe");
endmodule
bind sar_ctrl sar_ctrl_properties #(.CONV_CYCLES(CONV_CYCLES)) i_props (
  .core_clk(core_clk),
  .nrst(nrst),
  .convert_strobe(convert_strobe),
  .busy(busy),
  .chain_select(chain_select),
  .shared_enable_or_serial_in(shared_enable_or_serial_in),
  .serial_out_oe(serial_out_oe)
);
`default_nettype wire

// file: verification/sar_host.sv
`timescale 1ns/1ps
`default_nettype none
module sar_host (
  // Inputs
  input wire logic core_clk,
  input wire logic serial_out,
  // Host drives
  output logic convert_strobe = 1'b0,
  output logic shift_clk = 1'b0,
  output logic shared_enable_or_serial_in = 1'b1
);
  task automatic conv();
    @(posedge core_clk) convert_strobe <= 1'b1;
    repeat (2) @(posedge core_clk);
    convert_strobe <= 1'b0;
  endtask
  // Three load edges, then 32 shifts; clock still outside frames
  task automatic frame(input logic [31:0] din, output logic [31:0] dout);
    for (int i = -3; i < 32; i++)
    begin
      shared_enable_or_serial_in = din[i < 0 ? 31 : 31 - i];
      #62.5 dout = {dout[30:0], serial_out};
      shift_clk = 1'b1;
      #62.5 shift_clk = 1'b0;
    end
    shared_enable_or_serial_in = 1'b1;
  endtask
endmodule
`default_nettype wire

// file: verification/tb_sar_adc_serial_readout.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_serial_readout;
  logic core_clk = 1'b0, nrst = 1'b0, nrst_link = 1'b0, chain_select = 1'b0, gain_compress_select = 1'b1;
  logic [15:0] sample_code = 16'h0000;
  logic convert_strobe, shift_clk, shared_enable_or_serial_in, busy, serial_out, serial_out_oe;
  logic [31:0] got;
  int bad_count = 0;
  int n_compared = 0;
  always #10 core_clk = ~core_clk;
  sar_ctrl #(.CONV_CYCLES(4)) i_dut (
    .core_clk(core_clk),
    .nrst(nrst),
    .shift_clk(shift_clk),
    .nrst_link(nrst_link),
    .convert_strobe(convert_strobe),
    .busy(busy),
    .sample_code(sample_code),
    .chain_select(chain_select),
    .gain_compress_select(gain_compress_select),
    .shared_enable_or_serial_in(shared_enable_or_serial_in),
    .serial_out(serial_out),
    .serial_out_oe(serial_out_oe)
  );
  sar_host i_host (
    .core_clk(core_clk),
    .serial_out(serial_out),
    .convert_strobe(convert_strobe),
    .shift_clk(shift_clk),
    .shared_enable_or_serial_in(shared_enable_or_serial_in)
  );
  task automatic check(input logic [15:0] seen, input logic [15:0] w);
    n_compared++;
    if (seen !== w)
    begin
      bad_count++;
      $display("MISMATCH %0t got %h want %h", $time, seen, w);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic t_conv(input logic [15:0] c, input logic gc, input logic [31:0] din, input logic [15:0] w);
    @(posedge core_clk);
    sample_code <= c;
    gain_compress_select <= gc;
    i_host.conv();
    repeat (2) @(posedge core_clk);
    #1 check(16'(busy), 16'h1);
    for (int i = 0; i < 20 && busy !== 1'b0; i++) #20;
    check(16'(busy), 16'h0);
    i_host.frame(din, got);
    check(got[31:16], w);
    if (chain_select) check(got[15:0], din[31:16]);
  endtask
  task automatic t_oe(input logic ch, input logic en, input logic w);
    @(posedge core_clk);
    chain_select <= ch;
    i_host.shared_enable_or_serial_in <= en;
    repeat (8) @(posedge core_clk);
    #1 check(16'(serial_out_oe), 16'(w));
  endtask
  initial
  begin
    fork
      i_host.frame(32'h0, got);
    join_none
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    wait fork;
    @(posedge core_clk);
    nrst_link <= 1'b1;
    t_conv(16'h0000, 1'b1, 32'h0, 16'h8000);
    t_conv(16'hffff, 1'b1, 32'h0, 16'h7fff);
    t_conv(16'ha800, 1'b0, 32'h0, 16'h2000);
    t_conv(16'h5800, 1'b0, 32'h0, 16'he000);
    t_oe(1'b0, 1'b1, 1'b0);
    t_oe(1'b0, 1'b0, 1'b1);
    t_oe(1'b1, 1'b1, 1'b1);
    t_conv(16'h1234, 1'b1, 32'hc3a50000, 16'h9234);
    wrap_up();
  end
  initial
  begin
    #100000;
    bad_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
